//--- frdwc_pkg.sv
package frdwc_pkg;

	localparam int ADDR_BITS = 24;

	// Read opcodes. The three auxiliary reads share the fast read timing.
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_FAST_READ_DR = 8'h0D;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO_DR = 8'hBD;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_IO_DR = 8'hED;
	localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
	localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;
	localparam logic [7:0] OP_INFO_ROW = 8'h68;

	// Default dummy counts used when the dummy field is zero.
	localparam logic [3:0] DUMMY_FAST_SPI = 4'h8;
	localparam logic [3:0] DUMMY_FAST_QUAD = 4'h6;
	localparam logic [3:0] DUMMY_DUAL_OUT = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
	localparam logic [3:0] DUMMY_QUAD_OUT = 4'h8;
	localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;

	// Read parameter register layout.
	localparam int DUMMY_LSB = 3;
	localparam int DUMMY_MSB = 6;
	localparam int WRAP_EN_BIT = 2;
	localparam int BURST_HI_BIT = 1;
	localparam int BURST_LO_BIT = 0;
	localparam logic [23:0] BURST_MIN_BYTES = 24'h00_0008;
	localparam logic [7:0] READ_PARAM_RESET = 8'h00;

	// Host controller registers.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OPCODE = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_LEN = 8'h0C;
	localparam logic [7:0] REG_CFG = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_DATA = 8'h18;
	localparam int CTRL_GO_BIT = 0;
	localparam int CFG_QUAD_BIT = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_VALID_BIT = 1;
	localparam int STAT_BAD_BIT = 2;
	localparam int STAT_COUNT_LSB = 8;
	localparam logic [7:0] LEN_RESET = 8'h01;

	// Serial clock timing.
	localparam int MCLK_PERIOD_NS = 100;
	localparam int SCK_SLOWEST_LIMIT_MHZ = 33;
	localparam int SCK_MIN_PERIOD_NS = (1000 + SCK_SLOWEST_LIMIT_MHZ - 1) / SCK_SLOWEST_LIMIT_MHZ;
	localparam int SCK_MIN_HALF_CYCLES = (SCK_MIN_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);
	localparam int SCK_HALF_CYCLES = 8;

	typedef struct packed {
		logic valid;
		logic dtr;
		logic [2:0] addrW;
		logic [2:0] dataW;
		logic [3:0] defDummy;
	} frdwc_cmd_t;

	function automatic frdwc_cmd_t frdwc_decode(input logic [7:0] op, input logic quad);
		frdwc_cmd_t c;
		c = '0;
		case (op)
			OP_FAST_READ, OP_FAST_READ_DR, OP_UNIQUE_ID, OP_PARAM_TABLE, OP_INFO_ROW: begin
				c.valid = 1'b1;
				c.dtr = (op == OP_FAST_READ_DR);
				c.addrW = quad ? 3'h4 : 3'h1;
				c.dataW = quad ? 3'h4 : 3'h1;
				c.defDummy = quad ? DUMMY_FAST_QUAD : DUMMY_FAST_SPI;
			end
			OP_DUAL_OUT: begin
				c.valid = ~quad;
				c.addrW = 3'h1;
				c.dataW = 3'h2;
				c.defDummy = DUMMY_DUAL_OUT;
			end
			OP_DUAL_IO, OP_DUAL_IO_DR: begin
				c.valid = ~quad;
				c.dtr = (op == OP_DUAL_IO_DR);
				c.addrW = 3'h2;
				c.dataW = 3'h2;
				c.defDummy = DUMMY_DUAL_IO;
			end
			OP_QUAD_OUT: begin
				c.valid = ~quad;
				c.addrW = 3'h1;
				c.dataW = 3'h4;
				c.defDummy = DUMMY_QUAD_OUT;
			end
			OP_QUAD_IO, OP_QUAD_IO_DR: begin
				c.valid = 1'b1;
				c.dtr = (op == OP_QUAD_IO_DR);
				c.addrW = 3'h4;
				c.dataW = 3'h4;
				c.defDummy = DUMMY_QUAD_IO;
			end
			default: c = '0;
		endcase
		return c;
	endfunction

	function automatic logic [3:0] frdwc_dummy(input logic [3:0] field, input logic [3:0] defCount);
		return (field == 4'h0) ? defCount : field;
	endfunction

	function automatic logic [5:0] frdwc_last_slot(input logic [2:0] w);
		return (w == 3'h4) ? 6'h05 : (w == 3'h2) ? 6'h0B : 6'h17;
	endfunction

endpackage

//--- frdwc_link_if.sv
`timescale 1ns/10ps
interface frdwc_link_if;
	logic sck;
	logic ceN;
	logic [3:0] hostIoOut;
	logic [3:0] hostIoOe;
	logic [3:0] devIoOut;
	logic [3:0] devIoOe;
	logic [3:0] ioLevel;

	// Undriven lines float high, as a weak pull-up would leave them.
	assign ioLevel = (hostIoOe & hostIoOut) | (~hostIoOe & devIoOe & devIoOut) | (~hostIoOe & ~devIoOe);

	modport host (
		output sck,
		output ceN,
		output hostIoOut,
		output hostIoOe,
		input ioLevel
	);

	modport device (
		input sck,
		input ceN,
		input ioLevel,
		output devIoOut,
		output devIoOe
	);
endinterface

//--- frdwc_device_end.sv
`timescale 1ns/10ps
// Overview of operation
// - Wrap disabled: read wraps across whole array.
// - Wrap enabled: read wraps at burst boundary.
// - Dummy field zero selects per-command default.
// - Dummy field 1..15 gives exactly that count.
// - Single-wire fast read: 8 dummy, both rates.
// - Quad-instruction fast read: 6 dummy, both rates.
// - Dual-output read: 8 dummy, single rate only.
// - Dual I/O read: 4 dummy, both rates.
// - Quad-output read: 8 dummy, single rate only.
// - Quad I/O read: 6 dummy, every mode.
// - Auxiliary reads follow fast read dummy count.
// - Dual I/O double rate refused in quad mode.
// - Host programs enough dummy cycles.
// - Host releases lines during dummy cycles.
// - Host keeps serial clock within limits.
// - Burst codes select 8/16/32/64 bytes.
// - Dummy field sits in bits six to three.
// - Volatile parameters loaded from non-volatile copy.
module frdwc_device_end
	import frdwc_pkg::*;
#(
	parameter logic [7:0] PATTERN_SEED = 8'hA5
) (
	input wire logic mclk,
	input wire logic sys_rst,
	frdwc_link_if.device link,
	input wire logic [7:0] nvReadParam,
	input wire logic quadModeStrap,
	output logic [7:0] readParam,
	output logic quadActive,
	output logic [23:0] readAddr,
	output logic cmdRejected
);

	typedef enum {D_IDLE, D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} frdwc_dstate_t;

	frdwc_dstate_t state;
	logic loaded;
	logic sckS1, sckS2, sckS3;
	logic ceS1, ceS2;
	logic [3:0] ioS1, ioS2;
	frdwc_cmd_t cur;
	logic [5:0] slot;
	logic [23:0] inShift;
	logic [3:0] dummyLeft;
	logic started;
	logic [7:0] outShift;
	logic [2:0] outCnt;
	logic [3:0] ioOut;
	logic [3:0] ioOe;

	function automatic logic [23:0] nextReadAddr(input logic [23:0] a, input logic [7:0] p);
		logic [23:0] mask;
		mask = (BURST_MIN_BYTES << {p[BURST_HI_BIT], p[BURST_LO_BIT]}) - 24'h00_0001;
		if (p[WRAP_EN_BIT]) begin
			return (a & ~mask) | ((a + 24'h00_0001) & mask);
		end
		return a + 24'h00_0001;
	endfunction

	// Edges are found only after two synchroniser stages; the third stage is the history.
	logic sckRise, sckFall, deselect;
	assign sckRise = sckS2 & ~sckS3;
	assign sckFall = ~sckS2 & sckS3;
	assign deselect = ceS2;

	logic [2:0] inW;
	logic [23:0] nextShift;
	frdwc_cmd_t opInfo;
	logic [5:0] cmdLast;
	assign inW = (state == D_CMD) ? (quadActive ? 3'h4 : 3'h1) : cur.addrW;
	assign nextShift = (inW == 3'h4) ? {inShift[19:0], ioS2} :
		(inW == 3'h2) ? {inShift[21:0], ioS2[1:0]} : {inShift[22:0], ioS2[0]};
	assign opInfo = frdwc_decode(nextShift[7:0], quadActive);
	assign cmdLast = quadActive ? 6'h01 : 6'h07;

	logic [3:0] dummyCount;
	assign dummyCount = frdwc_dummy(readParam[DUMMY_MSB:DUMMY_LSB], cur.defDummy);

	// Double rate transfers add the second edge only once the phase has begun: address on a rising edge, data out on a falling one.
	logic addrCapture, outEdge;
	assign addrCapture = sckRise | (cur.dtr & started & sckFall);
	assign outEdge = sckFall | (cur.dtr & started & sckRise);

	// No array is kept: read data is an address pattern so that wrapping is visible on the link.
	logic [7:0] patByte, curByte, shiftedByte;
	logic [3:0] drvVal, drvOe;
	logic [2:0] outLast;
	assign patByte = readAddr[7:0] ^ readAddr[15:8] ^ readAddr[23:16] ^ PATTERN_SEED;
	assign curByte = (outCnt == 3'h0) ? patByte : outShift;
	assign shiftedByte = (cur.dataW == 3'h4) ? {curByte[3:0], 4'h0} :
		(cur.dataW == 3'h2) ? {curByte[5:0], 2'h0} : {curByte[6:0], 1'b0};
	assign drvVal = (cur.dataW == 3'h4) ? curByte[7:4] :
		(cur.dataW == 3'h2) ? {2'h0, curByte[7:6]} : {2'h0, curByte[7], 1'b0};
	assign drvOe = (cur.dataW == 3'h4) ? 4'hF : (cur.dataW == 3'h2) ? 4'h3 : 4'h2;
	assign outLast = (cur.dataW == 3'h4) ? 3'h1 : (cur.dataW == 3'h2) ? 3'h3 : 3'h7;

	assign link.devIoOut = ioOut;
	assign link.devIoOe = ioOe;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sckS1 <= 1'b0;
			sckS2 <= 1'b0;
			sckS3 <= 1'b0;
			ceS1 <= 1'b1;
			ceS2 <= 1'b1;
			ioS1 <= 4'hF;
			ioS2 <= 4'hF;
		end else begin
			sckS1 <= link.sck;
			sckS2 <= sckS1;
			sckS3 <= sckS2;
			ceS1 <= link.ceN;
			ceS2 <= ceS1;
			ioS1 <= link.ioLevel;
			ioS2 <= ioS1;
		end
	end

	// The stored copy is taken once, on the first edge after reset release.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			loaded <= 1'b0;
			readParam <= READ_PARAM_RESET;
			quadActive <= 1'b0;
		end else if (!loaded) begin
			loaded <= 1'b1;
			readParam <= nvReadParam;
			quadActive <= quadModeStrap;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= D_IDLE;
			cur <= '0;
			slot <= 6'h00;
			inShift <= 24'h00_0000;
			dummyLeft <= 4'h0;
			started <= 1'b0;
			outShift <= 8'h00;
			outCnt <= 3'h0;
			readAddr <= 24'h00_0000;
			ioOut <= 4'h0;
			ioOe <= 4'h0;
			cmdRejected <= 1'b0;
		end else begin
			cmdRejected <= 1'b0;
			if (deselect) begin
				state <= D_IDLE;
				ioOe <= 4'h0;
			end else begin
				unique case (state)
					D_IDLE: begin
						if (loaded) begin
							state <= D_CMD;
							slot <= 6'h00;
						end
					end
					D_CMD: begin
						if (sckRise) begin
							inShift <= nextShift;
							slot <= slot + 6'h01;
							if (slot == cmdLast) begin
								cur <= opInfo;
								slot <= 6'h00;
								started <= 1'b0;
								state <= opInfo.valid ? D_ADDR : D_IGNORE;
								cmdRejected <= ~opInfo.valid;
							end
						end
					end
					D_ADDR: begin
						if (addrCapture) begin
							inShift <= nextShift;
							started <= 1'b1;
							slot <= slot + 6'h01;
							if (slot == frdwc_last_slot(cur.addrW)) begin
								readAddr <= nextShift;
								dummyLeft <= dummyCount;
								state <= D_DUMMY;
							end
						end
					end
					D_DUMMY: begin
						ioOe <= 4'h0;
						if (sckRise) begin
							dummyLeft <= dummyLeft - 4'h1;
							if (dummyLeft == 4'h1) begin
								state <= D_DATA;
								started <= 1'b0;
								outCnt <= 3'h0;
							end
						end
					end
					D_DATA: begin
						if (outEdge) begin
							started <= 1'b1;
							ioOut <= drvVal;
							ioOe <= drvOe;
							outShift <= shiftedByte;
							if (outCnt == 3'h0) begin
								outCnt <= outLast;
								readAddr <= nextReadAddr(readAddr, readParam);
							end else begin
								outCnt <= outCnt - 3'h1;
							end
						end
					end
					D_IGNORE: begin
						ioOe <= 4'h0;
					end
				endcase
			end
		end
	end

endmodule

//--- frdwc_host_end.sv
`timescale 1ns/10ps
module frdwc_host_end
	import frdwc_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYCLES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	frdwc_link_if.host link
);

	typedef enum {H_IDLE, H_CMD, H_ADDR, H_DUMMY, H_DATA, H_END} frdwc_hstate_t;

	frdwc_hstate_t state;
	logic [7:0] opcode;
	logic [23:0] addrReg;
	logic [7:0] lenReg;
	logic [3:0] cfgDummy;
	logic cfgQuad;
	logic [7:0] dataReg;
	logic dataValid;
	logic badCmd;
	logic [7:0] bytesDone;
	frdwc_cmd_t cur;
	logic curQuad;
	logic [31:0] txShift;
	logic [7:0] rxShift;
	logic [5:0] slot;
	logic [2:0] rxCnt;
	logic [3:0] dummyLeft;
	logic [7:0] bytesLeft;
	logic started;
	logic [7:0] hcnt;
	logic sckR, ceNR;
	logic [3:0] ioOutR, ioOeR;
	logic [3:0] ioS1, ioS2;

	assign link.sck = sckR;
	assign link.ceN = ceNR;
	assign link.hostIoOut = ioOutR;
	assign link.hostIoOe = ioOeR;

	logic busy, idleWr, goReq, goOk, goBad, byteDone;
	frdwc_cmd_t reqInfo;
	assign busy = (state != H_IDLE);
	assign idleWr = regWr & ~busy;
	assign reqInfo = frdwc_decode(opcode, cfgQuad);
	assign goReq = idleWr & (regAddr == REG_CTRL) & regWdata[CTRL_GO_BIT];
	assign goOk = goReq & reqInfo.valid;
	assign goBad = goReq & ~reqInfo.valid;

	logic [31:0] readMux;
	assign readMux = (regAddr == REG_OPCODE) ? {24'h00_0000, opcode} :
		(regAddr == REG_ADDR) ? {8'h00, addrReg} :
		(regAddr == REG_LEN) ? {24'h00_0000, lenReg} :
		(regAddr == REG_CFG) ? {27'h000_0000, cfgQuad, cfgDummy} :
		(regAddr == REG_STATUS) ? {16'h0000, bytesDone, 5'h00, badCmd, dataValid, busy} :
		(regAddr == REG_DATA) ? {24'h00_0000, dataReg} : 32'h0000_0000;

	// Outputs move at mid half-period and inputs are sampled at its end, clear of the device's sync delay.
	logic midTick, edgeTick, riseNext;
	assign midTick = (hcnt == 8'(HALF / 2 - 1));
	assign edgeTick = (hcnt == 8'(HALF - 1));
	assign riseNext = ~sckR;

	logic [2:0] outW;
	logic addrSlot, driveNow, captureEdge, sampleEdge;
	assign outW = (state == H_CMD) ? (curQuad ? 3'h4 : 3'h1) : cur.addrW;
	assign addrSlot = riseNext | (cur.dtr & started);
	assign driveNow = midTick & (((state == H_CMD) & riseNext) | ((state == H_ADDR) & addrSlot));
	assign captureEdge = edgeTick & (((state == H_CMD) & riseNext) | ((state == H_ADDR) & addrSlot));
	assign sampleEdge = edgeTick & (state == H_DATA) & (riseNext | (cur.dtr & started));

	logic [3:0] txVal, txOe;
	logic [31:0] txNext;
	assign txVal = (outW == 3'h4) ? txShift[31:28] : (outW == 3'h2) ? {2'h0, txShift[31:30]} : {3'h0, txShift[31]};
	assign txOe = (outW == 3'h4) ? 4'hF : (outW == 3'h2) ? 4'h3 : 4'h1;
	assign txNext = (outW == 3'h4) ? {txShift[27:0], 4'h0} :
		(outW == 3'h2) ? {txShift[29:0], 2'h0} : {txShift[30:0], 1'b0};

	logic [7:0] rxNext;
	logic [2:0] rxLast;
	assign rxNext = (cur.dataW == 3'h4) ? {rxShift[3:0], ioS2} :
		(cur.dataW == 3'h2) ? {rxShift[5:0], ioS2[1:0]} : {rxShift[6:0], ioS2[1]};
	assign rxLast = (cur.dataW == 3'h4) ? 3'h1 : (cur.dataW == 3'h2) ? 3'h3 : 3'h7;
	assign byteDone = sampleEdge & (rxCnt == rxLast);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ioS1 <= 4'hF;
			ioS2 <= 4'hF;
		end else begin
			ioS1 <= link.ioLevel;
			ioS2 <= ioS1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			opcode <= OP_FAST_READ;
			addrReg <= 24'h00_0000;
			lenReg <= LEN_RESET;
			cfgDummy <= 4'h0;
			cfgQuad <= 1'b0;
			badCmd <= 1'b0;
			dataValid <= 1'b0;
			regRdata <= 32'h0000_0000;
		end else begin
			regRdata <= regRd ? readMux : 32'h0000_0000;
			if (idleWr && regAddr == REG_OPCODE) begin
				opcode <= regWdata[7:0];
			end
			if (idleWr && regAddr == REG_ADDR) begin
				addrReg <= regWdata[23:0];
			end
			if (idleWr && regAddr == REG_LEN) begin
				lenReg <= regWdata[7:0];
			end
			if (idleWr && regAddr == REG_CFG) begin
				cfgDummy <= regWdata[3:0];
				cfgQuad <= regWdata[CFG_QUAD_BIT];
			end
			badCmd <= goBad | (badCmd & ~goOk);
			// A byte landing in the cycle its flag is read keeps the flag set.
			dataValid <= byteDone | (dataValid & ~(regRd & (regAddr == REG_DATA)));
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= H_IDLE;
			cur <= '0;
			curQuad <= 1'b0;
			txShift <= 32'h0000_0000;
			rxShift <= 8'h00;
			slot <= 6'h00;
			rxCnt <= 3'h0;
			dummyLeft <= 4'h0;
			bytesLeft <= 8'h00;
			bytesDone <= 8'h00;
			started <= 1'b0;
			hcnt <= 8'h00;
			sckR <= 1'b0;
			ceNR <= 1'b1;
			ioOutR <= 4'h0;
			ioOeR <= 4'h0;
			dataReg <= 8'h00;
		end else begin
			hcnt <= (edgeTick || state == H_IDLE) ? 8'h00 : hcnt + 8'h01;
			if (edgeTick && state != H_IDLE && state != H_END) begin
				sckR <= ~sckR;
			end
			if (driveNow) begin
				ioOutR <= txVal;
				ioOeR <= txOe;
				txShift <= txNext;
			end
			unique case (state)
				H_IDLE: begin
					if (goOk) begin
						state <= H_CMD;
						cur <= reqInfo;
						curQuad <= cfgQuad;
						txShift <= {opcode, addrReg};
						ceNR <= 1'b0;
						slot <= 6'h00;
						bytesLeft <= lenReg;
						bytesDone <= 8'h00;
					end
				end
				H_CMD: begin
					if (captureEdge) begin
						slot <= slot + 6'h01;
						if (slot == (curQuad ? 6'h01 : 6'h07)) begin
							slot <= 6'h00;
							started <= 1'b0;
							state <= H_ADDR;
						end
					end
				end
				H_ADDR: begin
					if (captureEdge) begin
						started <= 1'b1;
						slot <= slot + 6'h01;
						if (slot == frdwc_last_slot(cur.addrW)) begin
							dummyLeft <= frdwc_dummy(cfgDummy, cur.defDummy);
							state <= H_DUMMY;
						end
					end
				end
				H_DUMMY: begin
					if (midTick) begin
						ioOeR <= 4'h0;
					end
					if (edgeTick && riseNext) begin
						dummyLeft <= dummyLeft - 4'h1;
						if (dummyLeft == 4'h1) begin
							state <= H_DATA;
							started <= 1'b0;
							rxCnt <= 3'h0;
						end
					end
				end
				H_DATA: begin
					if (edgeTick) begin
						started <= 1'b1;
					end
					if (sampleEdge) begin
						rxShift <= rxNext;
						rxCnt <= byteDone ? 3'h0 : rxCnt + 3'h1;
					end
					if (byteDone) begin
						dataReg <= rxNext;
						bytesDone <= bytesDone + 8'h01;
						bytesLeft <= bytesLeft - 8'h01;
						if (bytesLeft == 8'h01) begin
							state <= H_END;
						end
					end
				end
				H_END: begin
					// A full half period keeps the last high phase as long as every other one.
					if (edgeTick) begin
						sckR <= 1'b0;
						ceNR <= 1'b1;
						state <= H_IDLE;
					end
				end
			endcase
		end
	end

endmodule

//--- frdwc_link_assertions.sv
`timescale 1ns/10ps
module frdwc_link_assertions (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic ceN,
	input wire logic [3:0] hostIoOut,
	input wire logic [3:0] hostIoOe,
	input wire logic [3:0] devIoOut,
	input wire logic [3:0] devIoOe,
	input wire logic [3:0] ioLevel
);
	logic sckQ;
	logic [4:0] gapCnt;
	logic gapStep;

	// Counting only while both ends are released isolates the dummy gap from address and data.
	assign gapStep = ~ceN & sck & ~sckQ & (hostIoOe == 4'h0) & (devIoOe == 4'h0);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sckQ <= 1'h0;
			gapCnt <= 5'h00;
		end else begin
			sckQ <= sck;
			gapCnt <= ceN ? 5'h00 : gapCnt + {4'h0, gapStep};
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	no_contention_a: assert property ((hostIoOe & devIoOe) == 4'h0)
		else $error("both ends drive one data line");
	dummy_range_a: assert property ($rose(|devIoOe) |-> gapCnt >= 5'h01 && gapCnt <= 5'h0F)
		else $error("dummy gap outside one to fifteen clocks");
	dummy_quiet_a: assert property ($fell(|hostIoOe) && !ceN |-> (devIoOe == 4'h0) [*8])
		else $error("device drove right after host release");
	drive_on_low_a: assert property ($rose(|devIoOe) |-> !sck)
		else $error("device began driving while clock high");
	release_at_end_a: assert property ($rose(ceN) |-> ##[1:6] (devIoOe == 4'h0))
		else $error("device kept driving after deselect");
	idle_released_a: assert property (ceN [*8] |-> devIoOe == 4'h0)
		else $error("device drives while deselected");
	sck_half_a: assert property ($changed(sck) |=> $stable(sck) [*7])
		else $error("serial clock half period too short");
	frame_start_a: assert property ($fell(ceN) |-> !sck [*4])
		else $error("frame began with clock high");

	cover property ($rose(|devIoOe) && gapCnt == 5'h0F);
	cover property ($rose(|devIoOe) && gapCnt == 5'h01);
	cover property ($rose(|devIoOe) && gapCnt == 5'h04);
endmodule

//--- test_flash_read_dummy_wrap_config.sv
`timescale 1ns/10ps
module test_flash_read_dummy_wrap_config
	import frdwc_pkg::*;
;
	localparam logic [7:0] PATTERN = 8'hA5; // Arbitrary read-data seed.
	logic mclk, sys_rst, regWr, regRd, quadModeStrap, rejB, quadOn, rejA;
	logic [7:0] regAddr, nvReadParam, readParam;
	logic [31:0] regWdata, regRdata, s;
	logic [23:0] a, devAddr;
	logic sckQ = 1'h0, devOnQ = 1'h0, ceNQ = 1'h1, rejSeenB = 1'h0, devOnB = 1'h0, rejSeenA = 1'h0;
	logic [7:0] opShift = 8'h00, opSeen = 8'h00, bitCnt = 8'h00, dumCnt = 8'h00, dumSeen = 8'h00, frames = 8'h00;
	int failCount = 0;
	int checkCount = 0;
	int i;
	logic [7:0] spiOps [11] = '{OP_FAST_READ, OP_FAST_READ_DR, OP_DUAL_OUT, OP_DUAL_IO, OP_DUAL_IO_DR,
		OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_IO_DR, OP_UNIQUE_ID, OP_PARAM_TABLE, OP_INFO_ROW};
	logic [3:0] spiDum [11] = '{4'h8, 4'h8, 4'h8, 4'h4, 4'h4, 4'h8, 4'h6, 4'h6, 4'h8, 4'h8, 4'h8};
	logic [7:0] quadOps [5] = '{OP_FAST_READ, OP_FAST_READ_DR, OP_QUAD_IO, OP_QUAD_IO_DR, OP_PARAM_TABLE};
	logic [3:0] wrapDum [4] = '{4'h1, 4'hF, 4'h7, 4'h2};

	frdwc_link_if lnk();
	frdwc_link_if lnkB();

	frdwc_host_end i_frdwc_host_end (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(lnk));
	frdwc_device_end #(.PATTERN_SEED(PATTERN)) i_frdwc_device_end (.mclk(mclk), .sys_rst(sys_rst), .link(lnk),
		.nvReadParam(nvReadParam), .quadModeStrap(quadModeStrap), .readParam(readParam), .quadActive(quadOn),
		.readAddr(devAddr), .cmdRejected(rejA));
	// A second device faces a bench driver that sends what a correct host never would.
	frdwc_device_end #(.PATTERN_SEED(PATTERN)) i_frdwc_device_end_b (.mclk(mclk), .sys_rst(sys_rst), .link(lnkB),
		.nvReadParam(8'h00), .quadModeStrap(1'h1), .readParam(), .quadActive(), .readAddr(), .cmdRejected(rejB));
	frdwc_link_assertions i_frdwc_link_assertions (.mclk(mclk), .sys_rst(sys_rst), .sck(lnk.sck), .ceN(lnk.ceN),
		.hostIoOut(lnk.hostIoOut), .hostIoOe(lnk.hostIoOe), .devIoOut(lnk.devIoOut), .devIoOe(lnk.devIoOe),
		.ioLevel(lnk.ioLevel));

	always @(posedge mclk) begin
		sckQ <= lnk.sck;
		devOnQ <= |lnk.devIoOe;
		ceNQ <= lnk.ceN;
		if (rejB)
			rejSeenB <= 1'h1;
		if (|lnkB.devIoOe)
			devOnB <= 1'h1;
		if (rejA)
			rejSeenA <= 1'h1;
		if (!lnk.ceN && ceNQ)
			frames <= frames + 8'h01;
		if (lnk.ceN) begin
			bitCnt <= 8'h00;
			dumCnt <= 8'h00;
		end else if (lnk.sck && !sckQ) begin
			opShift <= {opShift[6:0], lnk.ioLevel[0]};
			bitCnt <= bitCnt + 8'h01;
			if (bitCnt == 8'h07)
				opSeen <= {opShift[6:0], lnk.ioLevel[0]};
			if (lnk.hostIoOe == 4'h0 && lnk.devIoOe == 4'h0)
				dumCnt <= dumCnt + 8'h01;
		end
		if ((|lnk.devIoOe) && !devOnQ)
			dumSeen <= dumCnt;
	end

	task automatic completeRun();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checkCount++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		regAddr <= ad;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge mclk);
		regWr <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		regAddr <= ad;
		regRd <= 1'h1;
		@(posedge mclk);
		regRd <= 1'h0;
		@(posedge mclk);
		d = regRdata;
	endtask

	task automatic resetDut(input logic [7:0] p, input logic q);
		sys_rst <= 1'h1;
		nvReadParam <= p;
		quadModeStrap <= q;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'h0;
		repeat (3) @(posedge mclk);
		chk("read param", {24'h00_0000, p}, {24'h00_0000, readParam});
		chk("quad mode", {31'h0000_0000, q}, {31'h0000_0000, quadOn});
	endtask

	task automatic waitIdle();
		logic [31:0] r;
		r = 32'h0000_0001;
		for (int n = 0; n < 2000 && r[0]; n++)
			rd(REG_STATUS, r);
		if (r[0]) begin
			$display("mismatch busy expected 0 seen 1");
			failCount++;
			completeRun();
		end
	endtask

	task automatic doRead(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] len,
		input logic [3:0] dum, input logic [23:0] last);
		logic [31:0] r;
		wr(REG_OPCODE, {24'h00_0000, op});
		wr(REG_ADDR, {8'h00, ad});
		wr(REG_LEN, {24'h00_0000, len});
		wr(REG_CFG, {27'h000_0000, quadModeStrap, nvReadParam[6:3]});
		wr(REG_CTRL, 32'h0000_0001);
		// Busy must drop this write, so the opcode read back below stays unchanged.
		wr(REG_OPCODE, 32'h0000_00FF);
		waitIdle();
		rd(REG_OPCODE, r);
		chk("opcode kept", {24'h00_0000, op}, r);
		rd(REG_STATUS, r);
		chk("status", {16'h0000, len, 8'h02}, r);
		rd(REG_DATA, r);
		chk("data", {24'h00_0000, last[7:0] ^ last[15:8] ^ last[23:16] ^ PATTERN}, r);
		chk("dummy", {28'h000_0000, dum}, {24'h00_0000, dumSeen});
		if (!quadModeStrap)
			chk("opcode wire", {24'h00_0000, op}, {24'h00_0000, opSeen});
	endtask

	task automatic refuse(input logic [7:0] op);
		logic [31:0] r;
		logic [7:0] f;
		f = frames;
		wr(REG_OPCODE, {24'h00_0000, op});
		wr(REG_CTRL, 32'h0000_0001);
		rd(REG_STATUS, r);
		chk("bad flag", 32'h0000_0001, {31'h0000_0000, r[2]});
		chk("no frame", {24'h00_0000, f}, {24'h00_0000, frames});
	endtask

	task automatic clkB();
		repeat (SCK_HALF_CYCLES) @(posedge mclk);
		lnkB.sck <= 1'h1;
		repeat (SCK_HALF_CYCLES) @(posedge mclk);
		lnkB.sck <= 1'h0;
	endtask

	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		sys_rst = 1'h1;
		regAddr = 8'h00;
		regWdata = 32'h0000_0000;
		regWr = 1'h0;
		regRd = 1'h0;
		nvReadParam = 8'h00;
		quadModeStrap = 1'h0;
		lnkB.sck = 1'h0;
		lnkB.ceN = 1'h1;
		lnkB.hostIoOut = 4'h0;
		lnkB.hostIoOe = 4'h0;
		@(posedge mclk);
		resetDut(8'h00, 1'h0);
		rd(REG_OPCODE, s);
		chk("opcode reset", 32'h0000_000B, s);
		rd(REG_LEN, s);
		chk("len reset", 32'h0000_0001, s);
		rd(8'hFC, s);
		chk("unmapped", 32'h0000_0000, s);
		for (i = 0; i < 11; i++)
			doRead(spiOps[i], 24'h01_2345, 8'h02, spiDum[i], 24'h01_2346);
		resetDut(8'h00, 1'h1);
		for (i = 0; i < 5; i++)
			doRead(quadOps[i], 24'h03_0000, 8'h01, 4'h6, 24'h03_0000);
		refuse(OP_DUAL_IO_DR);
		refuse(OP_QUAD_OUT);
		resetDut(8'h7B, 1'h1);
		doRead(OP_QUAD_IO, 24'hFF_FFFE, 8'h04, 4'hF, 24'h00_0001);
		chk("read addr", 32'h0000_0002, {8'h00, devAddr});
		for (i = 0; i < 4; i++) begin
			resetDut({1'h0, wrapDum[i], 1'h1, 2'(i)}, 1'h0);
			a = 24'h12_33FE + (24'h00_0008 << i);
			doRead(OP_FAST_READ, a, 8'h04, wrapDum[i], 24'h12_3401);
			chk("read addr", 32'h0012_3402, {8'h00, devAddr});
		end
		lnkB.ceN <= 1'h0;
		lnkB.hostIoOe <= 4'hF;
		lnkB.hostIoOut <= OP_DUAL_IO_DR[7:4];
		clkB();
		lnkB.hostIoOut <= OP_DUAL_IO_DR[3:0];
		clkB();
		lnkB.hostIoOe <= 4'h0;
		repeat (16) clkB();
		lnkB.ceN <= 1'h1;
		@(posedge mclk);
		chk("refused opcode", 32'h0000_0001, {31'h0000_0000, rejSeenB});
		chk("refused drive", 32'h0000_0000, {31'h0000_0000, devOnB});
		chk("host filtered", 32'h0000_0000, {31'h0000_0000, rejSeenA});
		completeRun();
	end
endmodule
